/* rtl/pg_tree_regs.svh */
// Register offsets, reset values and field positions of the power-good tree masks
//
// Function
// - First mask byte: bit7 ldo_rail_b, bit6 load_switch_a, bits5..0 stepdown_6..1; 0 includes.
// - A mask bit of 1 excludes its source; that source cannot affect the output.
// - Second mask byte: control inputs 5,4,2,1, termination LDO, load_switch_b2, b1, ldo_rail_c.
// - pg_out_a first mask at a4h, reset c2h.
// - pg_out_a second mask at a5h, reset afh.
// - pg_out_d first mask at a6h, reset zero, all included.
// - pg_out_d second mask at a7h, reset zero, all included.
// - Each output has its own readable and writable mask bits.
`ifndef PG_TREE_REGS_SVH
`define PG_TREE_REGS_SVH

// ****************************************************************
// Offsets
// ****************************************************************
`define PG_OFS_A_LOW 8'ha4
`define PG_OFS_A_HIGH 8'ha5
`define PG_OFS_D_LOW 8'ha6
`define PG_OFS_D_HIGH 8'ha7

// ****************************************************************
// Reset values
// ****************************************************************
`define PG_RST_A_LOW 8'hc2
`define PG_RST_A_HIGH 8'haf
`define PG_RST_D_LOW 8'h00
`define PG_RST_D_HIGH 8'h00

// ****************************************************************
// Field positions, low mask byte
// ****************************************************************
`define PG_BIT_LDO_B_EXCLUDE 7
`define PG_BIT_SWITCH_A_EXCLUDE 6
`define PG_BIT_STEPDOWN6_EXCLUDE 5
`define PG_BIT_STEPDOWN1_EXCLUDE 0

// ****************************************************************
// Field positions, high mask byte
// ****************************************************************
`define PG_BIT_CONTROL5_EXCLUDE 7
`define PG_BIT_CONTROL4_EXCLUDE 6
`define PG_BIT_CONTROL2_EXCLUDE 5
`define PG_BIT_CONTROL1_EXCLUDE 4
`define PG_BIT_TERMINATION_EXCLUDE 3
`define PG_BIT_SWITCH_B2_EXCLUDE 2
`define PG_BIT_SWITCH_B1_EXCLUDE 1
`define PG_BIT_LDO_C_EXCLUDE 0

// ****************************************************************
// Widths and constants
// ****************************************************************
`define PG_BYTE_W 8
`define PG_SRC_W 16
`define PG_ALL_EXCLUDED 16'hffff
`define PG_READ_ZERO 8'h00

`endif

/* rtl/pg_tree_pkg.sv */
// Types shared by the power-good tree mask block
`include "pg_tree_regs.svh"
package pg_tree_pkg;

  typedef logic [`PG_BYTE_W-1:0] mask_byte_t;
  typedef logic [`PG_SRC_W-1:0] src_vec_t;

  typedef struct packed {
    src_vec_t sync_first;
    src_vec_t sync_second;
    mask_byte_t a_low;
    mask_byte_t a_high;
    mask_byte_t d_low;
    mask_byte_t d_high;
    logic out_a;
    logic out_d;
    mask_byte_t rdata;
  } pg_state_t;

endpackage : pg_tree_pkg

/* rtl/pg_tree_and.sv */
// AND of one power-good tree with per-source exclusion
`timescale 1ns/1ns
`default_nettype none
module pg_tree_and #(
  parameter int WIDTH = 16
) (
  input wire logic [WIDTH-1:0] src_good, // Synchronised power-good sources
  input wire logic [WIDTH-1:0] exclude,  // 1 removes the source from the tree
  output logic all_good                  // High when every included source is good
);

  if (WIDTH < 1) begin : g_bad_width
    $error("pg_tree_and needs at least one source");
  end

  // An excluded source is forced to good, so a fully masked tree reads good
  assign all_good = &(src_good | exclude);

endmodule : pg_tree_and
`default_nettype wire

/* rtl/power_good_tree_mask.sv */
// Power-good aggregation for pg_out_a and pg_out_d with software masks
`timescale 1ns/1ns
`default_nettype none
`include "pg_tree_regs.svh"
module power_good_tree_mask (
  input wire logic ref_clk,                          // Device clock, 250 MHz
  input wire logic rst_n,                            // Asynchronous reset, active low
  input wire logic pg_stepdown_1,                    // Power good of stepdown_1
  input wire logic pg_stepdown_2,                    // Power good of stepdown_2
  input wire logic pg_stepdown_3,                    // Power good of stepdown_3
  input wire logic pg_stepdown_4,                    // Power good of stepdown_4
  input wire logic pg_stepdown_5,                    // Power good of stepdown_5
  input wire logic pg_stepdown_6,                    // Power good of stepdown_6
  input wire logic pg_load_switch_a,                 // Power good of load_switch_a
  input wire logic pg_ldo_rail_b,                    // Power good of ldo_rail_b
  input wire logic pg_ldo_rail_c,                    // Power good of ldo_rail_c
  input wire logic pg_load_switch_b1,                // Power good of load_switch_b1
  input wire logic pg_load_switch_b2,                // Power good of load_switch_b2
  input wire logic pg_termination_ldo,               // Power good of termination_ldo
  input wire logic control_input_1,                  // Control pin 1 level
  input wire logic control_input_2,                  // Control pin 2 level
  input wire logic control_input_4,                  // Control pin 4 level
  input wire logic control_input_5,                  // Control pin 5 level
  input wire logic [7:0] reg_addr,                   // Register offset from the host interface
  input wire logic reg_wr,                           // Write strobe, one cycle
  input wire pg_tree_pkg::mask_byte_t reg_wdata,     // Write data
  input wire logic reg_rd,                           // Read strobe, one cycle
  output var pg_tree_pkg::mask_byte_t reg_rdata,     // Read data, valid the cycle after reg_rd
  output logic reg_hit,                              // Address is one of the four masks
  output logic pg_out_a,                             // Aggregated power good, output a
  output logic pg_out_d                              // Aggregated power good, output d
);
  import pg_tree_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  pg_state_t state_q;
  pg_state_t state_d;
  src_vec_t raw_src;
  logic good_a;
  logic good_d;
  src_vec_t excl_a;
  src_vec_t excl_d;
  logic hit_a_low;
  logic hit_a_high;
  logic hit_d_low;
  logic hit_d_high;

  // Low byte mirrors the first mask register, high byte the second
  assign raw_src = {control_input_5, control_input_4, control_input_2, control_input_1,
                    pg_termination_ldo, pg_load_switch_b2, pg_load_switch_b1, pg_ldo_rail_c,
                    pg_ldo_rail_b, pg_load_switch_a, pg_stepdown_6, pg_stepdown_5,
                    pg_stepdown_4, pg_stepdown_3, pg_stepdown_2, pg_stepdown_1};

  // Exclusion vectors in source order, taken from next state
  assign excl_a = {state_d.a_high, state_d.a_low};
  assign excl_d = {state_d.d_high, state_d.d_low};

  // ****************************************************************
  // Address decode
  // ****************************************************************
  assign hit_a_low = (reg_addr == `PG_OFS_A_LOW);
  assign hit_a_high = (reg_addr == `PG_OFS_A_HIGH);
  assign hit_d_low = (reg_addr == `PG_OFS_D_LOW);
  assign hit_d_high = (reg_addr == `PG_OFS_D_HIGH);
  assign reg_hit = hit_a_low | hit_a_high | hit_d_low | hit_d_high;

  // ****************************************************************
  // Trees
  // ****************************************************************
  // Sources come from the second sync flop only; reading the first could pass a metastable level
  // Masks come from next state so a write reaches the pin one edge after it, not two
  pg_tree_and #(
    .WIDTH(`PG_SRC_W)
  ) u_tree_a (
    .src_good(state_q.sync_second),
    .exclude(excl_a),
    .all_good(good_a)
  );

  pg_tree_and #(
    .WIDTH(`PG_SRC_W)
  ) u_tree_d (
    .src_good(state_q.sync_second),
    .exclude(excl_d),
    .all_good(good_d)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    state_d = state_q;
    // Regulator flags and pins are asynchronous to ref_clk
    state_d.sync_first = raw_src;
    state_d.sync_second = state_q.sync_first;
    if (reg_wr) begin
      if (hit_a_low) begin
        state_d.a_low = reg_wdata;
      end
      if (hit_a_high) begin
        state_d.a_high = reg_wdata;
      end
      if (hit_d_low) begin
        state_d.d_low = reg_wdata;
      end
      if (hit_d_high) begin
        state_d.d_high = reg_wdata;
      end
    end
    if (reg_rd) begin
      unique case (1'b1)
        hit_a_low: state_d.rdata = state_q.a_low;
        hit_a_high: state_d.rdata = state_q.a_high;
        hit_d_low: state_d.rdata = state_q.d_low;
        hit_d_high: state_d.rdata = state_q.d_high;
        default: state_d.rdata = `PG_READ_ZERO;
      endcase
    end
    state_d.out_a = good_a;
    state_d.out_d = good_d;
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Outputs reset low: no tree is trusted before the sources are sampled
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_q.sync_first <= '0;
      state_q.sync_second <= '0;
      state_q.a_low <= `PG_RST_A_LOW;
      state_q.a_high <= `PG_RST_A_HIGH;
      state_q.d_low <= `PG_RST_D_LOW;
      state_q.d_high <= `PG_RST_D_HIGH;
      state_q.out_a <= 1'b0;
      state_q.out_d <= 1'b0;
      state_q.rdata <= `PG_READ_ZERO;
    end else begin
      state_q <= state_d;
    end
  end

  assign pg_out_a = state_q.out_a;
  assign pg_out_d = state_q.out_d;
  assign reg_rdata = state_q.rdata;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  logic seen_edge_q;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      seen_edge_q <= 1'b0;
    end else begin
      seen_edge_q <= 1'b1;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  sequence s_write_a_low;
    reg_wr && reg_addr == `PG_OFS_A_LOW;
  endsequence

  sequence s_write_d_high;
    reg_wr && reg_addr == `PG_OFS_D_HIGH;
  endsequence

  sequence s_write_a_high;
    reg_wr && reg_addr == `PG_OFS_A_HIGH;
  endsequence

  sequence s_write_d_low;
    reg_wr && reg_addr == `PG_OFS_D_LOW;
  endsequence

  sequence s_read_a_low;
    reg_rd && reg_addr == `PG_OFS_A_LOW;
  endsequence

  sequence s_read_a_high;
    reg_rd && reg_addr == `PG_OFS_A_HIGH;
  endsequence

  sequence s_read_d_low;
    reg_rd && reg_addr == `PG_OFS_D_LOW;
  endsequence

  sequence s_read_d_high;
    reg_rd && reg_addr == `PG_OFS_D_HIGH;
  endsequence

  a_reset_a_masks: assert property (
    !seen_edge_q |-> state_q.a_low == `PG_RST_A_LOW && state_q.a_high == `PG_RST_A_HIGH)
    else $error("pg_out_a masks not at reset value");

  a_reset_d_masks: assert property (
    !seen_edge_q |-> state_q.d_low == `PG_RST_D_LOW && state_q.d_high == `PG_RST_D_HIGH)
    else $error("pg_out_d masks not at reset value");

  a_write_low_effect: assert property (
    s_write_a_low |=> pg_out_a == &({$past(state_q.sync_second[15:8]) | state_q.a_high,
                                    $past(state_q.sync_second[7:0]) | $past(reg_wdata)}))
    else $error("mask write did not reach pg_out_a next cycle");

  a_write_independent: assert property (
    s_write_a_low |=> $stable(state_q.d_low) && $stable(state_q.d_high) && $stable(state_q.a_high))
    else $error("write to one mask disturbed another");

  a_write_readback: assert property (
    s_write_d_high ##1 (reg_rd && reg_addr == `PG_OFS_D_HIGH && !reg_wr) |=> reg_rdata == $past(reg_wdata, 2))
    else $error("mask read back differs from write");

  a_stepdown_one_in: assert property (
    !state_q.sync_second[0] && !state_d.a_low[0] |=> !pg_out_a)
    else $error("included stepdown_1 low but pg_out_a good");

  a_control_five_in: assert property (
    !state_q.sync_second[15] && !state_d.d_high[7] |=> !pg_out_d)
    else $error("included control_input_5 low but pg_out_d good");

  a_all_masked_good: assert property (
    seen_edge_q && {state_q.d_high, state_q.d_low} == 16'hffff |-> pg_out_d)
    else $error("fully masked tree not good");

  a_all_good_high: assert property (
    &state_q.sync_second |=> pg_out_a && pg_out_d)
    else $error("all sources good but an output low");

  a_unmapped_zero: assert property (
    reg_rd && !reg_hit |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // ****************************************************************
  // Register access checks
  // ****************************************************************
  a_write_high_effect: assert property (
    s_write_a_high |=> pg_out_a == &({$past(state_q.sync_second[15:8]) | $past(reg_wdata),
                                     $past(state_q.sync_second[7:0]) | state_q.a_low}))
    else $error("high mask write did not reach pg_out_a next cycle");

  a_write_d_effect: assert property (
    s_write_d_low |=> pg_out_d == &({$past(state_q.sync_second[15:8]) | state_q.d_high,
                                    $past(state_q.sync_second[7:0]) | $past(reg_wdata)}))
    else $error("mask write did not reach pg_out_d next cycle");

  a_write_d_independent: assert property (
    s_write_d_high |=> $stable(state_q.a_low) && $stable(state_q.a_high) && $stable(state_q.d_low))
    else $error("write to pg_out_d mask disturbed another");

  a_masks_hold: assert property (
    !reg_wr |=> $stable(state_q.a_low) && $stable(state_q.a_high)
                && $stable(state_q.d_low) && $stable(state_q.d_high))
    else $error("mask changed without a write");

  a_read_a_low: assert property (
    s_read_a_low |=> reg_rdata == $past(state_q.a_low))
    else $error("read of first pg_out_a mask wrong");

  a_read_a_high: assert property (
    s_read_a_high |=> reg_rdata == $past(state_q.a_high))
    else $error("read of second pg_out_a mask wrong");

  a_read_d_low: assert property (
    s_read_d_low |=> reg_rdata == $past(state_q.d_low))
    else $error("read of first pg_out_d mask wrong");

  a_read_d_high: assert property (
    s_read_d_high |=> reg_rdata == $past(state_q.d_high))
    else $error("read of second pg_out_d mask wrong");

  a_rdata_holds: assert property (
    !reg_rd |=> $stable(reg_rdata))
    else $error("read data changed without a read");

  a_hit_decode: assert property (
    reg_hit == (reg_addr >= `PG_OFS_A_LOW && reg_addr <= `PG_OFS_D_HIGH))
    else $error("register hit wrong for offset");

  // ****************************************************************
  // Tree checks
  // ****************************************************************
  a_tree_a_good: assert property (
    &(state_q.sync_second | excl_a) |=> pg_out_a)
    else $error("pg_out_a low with every included source good");

  a_tree_d_good: assert property (
    &(state_q.sync_second | excl_d) |=> pg_out_d)
    else $error("pg_out_d low with every included source good");

  a_all_masked_a: assert property (
    seen_edge_q && {state_q.a_high, state_q.a_low} == `PG_ALL_EXCLUDED |-> pg_out_a)
    else $error("fully masked pg_out_a tree not good");

  // One pair per source position: any included low source must pull its output down
  for (genvar b = 0; b < `PG_SRC_W; b++) begin : g_bit_checks
    a_bit_pulls_a: assert property (
      !state_q.sync_second[b] && !excl_a[b] |=> !pg_out_a)
      else $error("included low source left pg_out_a good");

    a_bit_pulls_d: assert property (
      !state_q.sync_second[b] && !excl_d[b] |=> !pg_out_d)
      else $error("included low source left pg_out_d good");
  end

endmodule : power_good_tree_mask
`default_nettype wire

/* sim/pg_source_model.sv */
// Far-side model: power-good sources and control pin levels seen by the tree
`timescale 1ns/1ns
`default_nettype none
module pg_source_model (
  input wire logic [15:0] level, // Wanted level of each source
  output logic [15:0] src        // Source wires in exclusion-vector order
);
  // ****************
  // Sources
  // ****************
  // Real rails move with no clock; the tree syncs them itself
  assign src = level;
endmodule : pg_source_model
`default_nettype wire

/* sim/power_good_tree_mask_bench.sv */
// Testbench for the power-good tree mask block
`timescale 1ns/1ns
`default_nettype none
`include "pg_tree_regs.svh"
module power_good_tree_mask_bench;
  import pg_tree_pkg::*;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  mask_byte_t reg_wdata = 8'h00;
  mask_byte_t reg_rdata;
  logic reg_hit;
  logic pg_out_a;
  logic pg_out_d;
  logic [15:0] level = 16'h0000;
  logic [15:0] src;
  logic [15:0] one;
  logic [7:0] pat [4] = '{8'h5a, 8'ha5, 8'h3c, 8'hc3};
  int num_errors = 0;
  int check_count = 0;
  int cycles = 0;
  // ****************
  // Structure
  // ****************
  always #2 ref_clk = ~ref_clk;
  pg_source_model u_pg_source_model (.level(level), .src(src));
  power_good_tree_mask u_power_good_tree_mask (
    .ref_clk(ref_clk), .rst_n(rst_n),
    .pg_stepdown_1(src[0]), .pg_stepdown_2(src[1]), .pg_stepdown_3(src[2]),
    .pg_stepdown_4(src[3]), .pg_stepdown_5(src[4]), .pg_stepdown_6(src[5]),
    .pg_load_switch_a(src[6]), .pg_ldo_rail_b(src[7]), .pg_ldo_rail_c(src[8]),
    .pg_load_switch_b1(src[9]), .pg_load_switch_b2(src[10]), .pg_termination_ldo(src[11]),
    .control_input_1(src[12]), .control_input_2(src[13]),
    .control_input_4(src[14]), .control_input_5(src[15]),
    .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .pg_out_a(pg_out_a), .pg_out_d(pg_out_d));
  // ****************
  // Tasks
  // ****************
  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp8
  task automatic cmp1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp1
  task automatic wr(input logic [7:0] a, input mask_byte_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr
  // Write then read the same offset on the very next edge
  task automatic wr_rd(input logic [7:0] a, input mask_byte_t d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp8(reg_rdata, d);
  endtask : wr_rd
  task automatic rd(input logic [7:0] a, input mask_byte_t exp, input logic hit);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    #1 cmp1(reg_hit, hit);
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 cmp8(reg_rdata, exp);
  endtask : rd
  task automatic setmask(input logic [15:0] a, input logic [15:0] d);
    wr(`PG_OFS_A_LOW, a[7:0]);
    wr(`PG_OFS_A_HIGH, a[15:8]);
    wr(`PG_OFS_D_LOW, d[7:0]);
    wr(`PG_OFS_D_HIGH, d[15:8]);
  endtask : setmask
  // Two sync flops and the output flop, plus one edge of margin
  task automatic srcs(input logic [15:0] v);
    @(posedge ref_clk);
    level <= v;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask : srcs
  task automatic report_and_stop();
    $display("checks=%0d mismatches=%0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop
  // ****************
  // Tests
  // ****************
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors++;
      report_and_stop();
    end
  end
  initial begin
    repeat (12) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`PG_OFS_A_LOW, 8'hc2, 1'b1);
    rd(`PG_OFS_A_HIGH, 8'haf, 1'b1);
    rd(`PG_OFS_D_LOW, 8'h00, 1'b1);
    rd(`PG_OFS_D_HIGH, 8'h00, 1'b1);
    rd(8'ha3, 8'h00, 1'b0);
    rd(8'ha8, 8'h00, 1'b0);
    srcs(16'h503d);
    cmp1(pg_out_a, 1'b1);
    cmp1(pg_out_d, 1'b0);
    $display("test reset values done");
    for (int i = 0; i < 4; i++) begin
      wr(8'(8'ha4 + i), pat[i]);
    end
    wr(8'ha8, 8'hff);
    for (int i = 0; i < 4; i++) begin
      rd(8'(8'ha4 + i), pat[i], 1'b1);
    end
    $display("test read write done");
    for (int i = 0; i < 16; i++) begin
      one = 16'h0001 << i;
      setmask(~one, one);
      srcs(~one);
      cmp1(pg_out_a, 1'b0);
      cmp1(pg_out_d, 1'b1);
    end
    $display("test tree mapping done");
    wr(`PG_OFS_A_HIGH, 8'hff);
    #1 cmp1(pg_out_a, 1'b1);
    wr(`PG_OFS_A_HIGH, 8'h7f);
    #1 cmp1(pg_out_a, 1'b0);
    wr(`PG_OFS_A_HIGH, 8'hff);
    srcs(16'h0000);
    cmp1(pg_out_a, 1'b1);
    cmp1(pg_out_d, 1'b0);
    srcs(16'hffff);
    cmp1(pg_out_a, 1'b1);
    cmp1(pg_out_d, 1'b1);
    wr_rd(`PG_OFS_D_HIGH, 8'h5a);
    $display("test mask timing done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    #1 cmp1(pg_out_a, 1'b0);
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(`PG_OFS_A_LOW, 8'hc2, 1'b1);
    rd(`PG_OFS_D_HIGH, 8'h00, 1'b1);
    $display("test second reset done");
    report_and_stop();
  end
endmodule : power_good_tree_mask_bench
`default_nettype wire
